// ===== rtl/lsjd_decoder.sv
// Purpose: decode and time logic-test, or/xor, string and branch instructions
// Assumes: fetch offers bytes with valid/ready; count register value given at opcode
// Notes: done pulses once the instruction's full cycle cost has elapsed
`timescale 1ns/1ps
module lsjd_decoder
  import lsjd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] byte_data,
  input wire logic byte_valid,
  output logic byte_ready,
  input wire logic [15:0] count_register,
  output logic busy,
  output logic done,
  output logic illegal,
  output lsjd_op_t op_info
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    lsjd_state_t st;
    lsjd_op_t op;
    logic [2:0] left;
    logic [15:0] cnt;
    logic done;
    logic illegal;
  } lsjd_regs_t;

  lsjd_regs_t r_q;
  lsjd_regs_t r_d;

  lsjd_kind_t c_kind;
  logic c_word;
  logic c_to_reg;
  logic c_modrm;
  logic [2:0] c_imm;

  lsjd_classify u_cls (
    .opc(byte_data),
    .kind(c_kind),
    .word(c_word),
    .to_reg(c_to_reg),
    .has_modrm(c_modrm),
    .imm_fixed(c_imm)
  );

  function automatic logic is_string(input lsjd_kind_t k);
    is_string = (k == LSJD_K_CMP) || (k == LSJD_K_SCAN) || (k == LSJD_K_LOAD) ||
      (k == LSJD_K_STORE) || (k == LSJD_K_IN) || (k == LSJD_K_OUT);
  endfunction

  function automatic logic [15:0] base_cost(input lsjd_kind_t k, input logic w);
    case (k)
      LSJD_K_TEST_ACC: base_cost = w ? LSJD_CYC_ACC_W : LSJD_CYC_ACC_B;
      LSJD_K_CMP: base_cost = LSJD_CYC_CMP;
      LSJD_K_SCAN: base_cost = LSJD_CYC_SCAN;
      LSJD_K_LOAD: base_cost = LSJD_CYC_LOAD;
      LSJD_K_STORE: base_cost = LSJD_CYC_STORE;
      LSJD_K_IN: base_cost = LSJD_CYC_PORT;
      LSJD_K_OUT: base_cost = LSJD_CYC_PORT;
      LSJD_K_BR_SHORT: base_cost = LSJD_CYC_BR;
      LSJD_K_BR_NEAR: base_cost = LSJD_CYC_BR;
      LSJD_K_BR_FAR: base_cost = LSJD_CYC_BR;
      default: base_cost = LSJD_CYC_ZERO;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  logic take;
  logic [1:0] m_mod;
  logic [2:0] m_mid;
  logic [31:0] loop_cost;
  assign take = byte_valid && byte_ready;
  assign m_mod = byte_data[LSJD_MOD_HI:LSJD_MOD_LO];
  assign m_mid = byte_data[LSJD_MID_HI:LSJD_MID_LO];
  assign loop_cost = 32'(LSJD_CYC_LOOP_CMP_BASE) + 32'(LSJD_CYC_CMP) * 32'(count_register);

  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.illegal = 1'b0;
    case (r_q.st)
      LSJD_S_IDLE, LSJD_S_OPC: begin
        if (take) begin
          if (byte_data == LSJD_OP_LOOP || byte_data == LSJD_OP_LOOP_Z) begin
            r_d.op.looped = 1'b1;
            r_d.op.loop_z = byte_data[0];
            r_d.st = LSJD_S_OPC;
          end else if (c_kind == LSJD_K_NONE ||
                       (r_q.op.looped && !is_string(c_kind)) ||
                       (r_q.op.loop_z && c_kind != LSJD_K_CMP && c_kind != LSJD_K_SCAN)) begin
            r_d.illegal = 1'b1;
            r_d.op = '0;
            r_d.st = LSJD_S_IDLE;
          end else begin
            r_d.op.kind = c_kind;
            r_d.op.word = c_word;
            r_d.op.to_reg = c_to_reg;
            r_d.op.mem = 1'b0;
            r_d.op.cycles = base_cost(c_kind, c_word);
            if (r_q.op.looped && c_kind == LSJD_K_CMP) begin
              r_d.op.cycles = loop_cost[15:0];
            end
            r_d.left = c_imm;
            if (c_modrm) begin
              r_d.st = LSJD_S_MODRM;
            end else if (c_imm != 3'h0) begin
              r_d.st = LSJD_S_BYTES;
            end else begin
              r_d.st = LSJD_S_EXEC;
            end
            r_d.cnt = LSJD_CYC_ONE;
          end
        end
      end
      LSJD_S_MODRM: begin
        if (take) begin
          r_d.cnt = r_q.cnt + LSJD_CYC_ONE;
          r_d.op.mem = (m_mod != LSJD_MOD_REG);
          r_d.st = LSJD_S_EXEC;
          if (r_q.op.kind == LSJD_K_TEST_IMM) begin
            if (m_mid != LSJD_MID_TEST) begin
              r_d.illegal = 1'b1;
              r_d.op = '0;
              r_d.st = LSJD_S_IDLE;
            end else begin
              r_d.op.cycles = (m_mod != LSJD_MOD_REG) ? LSJD_CYC_IMM_M : LSJD_CYC_IMM_R;
              r_d.left = r_q.op.word ? 3'h2 : 3'h1;
              r_d.st = LSJD_S_BYTES;
            end
          end else begin
            r_d.op.cycles = (m_mod != LSJD_MOD_REG) ? LSJD_CYC_RM : LSJD_CYC_RR;
          end
        end
      end
      LSJD_S_BYTES: begin
        if (take) begin
          r_d.cnt = r_q.cnt + LSJD_CYC_ONE;
          r_d.left = r_q.left - 3'h1;
          if (r_q.left == 3'h1) begin
            // last byte may already use up the whole cost
            if (r_q.cnt + LSJD_CYC_ONE >= r_q.op.cycles) begin
              r_d.st = LSJD_S_DONE;
            end else begin
              r_d.st = LSJD_S_EXEC;
            end
          end
        end
      end
      LSJD_S_EXEC: begin
        r_d.cnt = r_q.cnt + LSJD_CYC_ONE;
        if (r_q.cnt + LSJD_CYC_ONE >= r_q.op.cycles) begin
          r_d.st = LSJD_S_DONE;
        end
      end
      LSJD_S_DONE: begin
        r_d.done = 1'b1;
        r_d.st = LSJD_S_IDLE;
        r_d.op.looped = 1'b0;
        r_d.op.loop_z = 1'b0;
      end
      default: r_d.st = LSJD_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign byte_ready = (r_q.st == LSJD_S_IDLE) || (r_q.st == LSJD_S_OPC) ||
    (r_q.st == LSJD_S_MODRM) || (r_q.st == LSJD_S_BYTES);
  assign busy = (r_q.st != LSJD_S_IDLE);
  assign done = r_q.done;
  assign illegal = r_q.illegal;
  assign op_info = r_q.op;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  chk_branch_cost: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_EXEC && r_q.op.kind == LSJD_K_BR_NEAR) |-> r_q.op.cycles == LSJD_CYC_BR)
    else $error("branch cost wrong");
  chk_cmp_cost: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_EXEC && r_q.op.kind == LSJD_K_CMP && !r_q.op.looped) |->
    r_q.op.cycles == LSJD_CYC_CMP)
    else $error("compare cost wrong");
  chk_scan_cost: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_EXEC && r_q.op.kind == LSJD_K_SCAN) |-> r_q.op.cycles == LSJD_CYC_SCAN)
    else $error("scan cost wrong");
  chk_load_cost: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_EXEC && r_q.op.kind == LSJD_K_LOAD) |-> r_q.op.cycles == LSJD_CYC_LOAD)
    else $error("load cost wrong");
  chk_store_cost: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_EXEC && r_q.op.kind == LSJD_K_STORE) |-> r_q.op.cycles == LSJD_CYC_STORE)
    else $error("store cost wrong");
  chk_port_cost: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_EXEC && (r_q.op.kind == LSJD_K_IN || r_q.op.kind == LSJD_K_OUT)) |->
    r_q.op.cycles == LSJD_CYC_PORT)
    else $error("port string cost wrong");
  chk_acc_cost: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_EXEC && r_q.op.kind == LSJD_K_TEST_ACC) |->
    r_q.op.cycles == (r_q.op.word ? LSJD_CYC_ACC_W : LSJD_CYC_ACC_B))
    else $error("accumulator test cost wrong");
  chk_done_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_DONE) |=> (done && !busy))
    else $error("done not pulsed after execute");
  chk_rm_cost: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_EXEC && (r_q.op.kind == LSJD_K_OR || r_q.op.kind == LSJD_K_XOR)) |->
    r_q.op.cycles == (r_q.op.mem ? LSJD_CYC_RM : LSJD_CYC_RR))
    else $error("or/xor cost wrong");
  chk_imm_cost: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_BYTES && r_q.op.kind == LSJD_K_TEST_IMM) |->
    r_q.op.cycles == (r_q.op.mem ? LSJD_CYC_IMM_M : LSJD_CYC_IMM_R))
    else $error("immediate test cost wrong");
  chk_done_count: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r_q.st == LSJD_S_DONE) |-> r_q.cnt == r_q.op.cycles)
    else $error("done reached off the cycle cost");
endmodule

// ===== rtl/lsjd_pkg.sv
// Purpose: shared constants and types for the logic, string and branch decoder
// Assumes: byte-wide instruction stream, one byte offered per handshake
// Notes: cycle figures are totals from first opcode byte accepted to done
package lsjd_pkg;
  // ---------------------------------------------------------------------------
  // opcode patterns (w bit masked, d bit too for or/xor; repeat and branch bytes matched whole)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LSJD_MASK_W = 8'hFE;
  localparam logic [7:0] LSJD_MASK_DW = 8'hFC;
  localparam logic [7:0] LSJD_OP_TEST_RM = 8'h84;
  localparam logic [7:0] LSJD_OP_GRP3 = 8'hF6;
  localparam logic [7:0] LSJD_OP_TEST_ACC = 8'hA8;
  localparam logic [7:0] LSJD_OP_OR_RM = 8'h08;
  localparam logic [7:0] LSJD_OP_XOR_RM = 8'h30;
  localparam logic [7:0] LSJD_OP_CMP_STR = 8'hA6;
  localparam logic [7:0] LSJD_OP_SCAN_STR = 8'hAE;
  localparam logic [7:0] LSJD_OP_LOAD_STR = 8'hAC;
  localparam logic [7:0] LSJD_OP_STORE_STR = 8'hAA;
  localparam logic [7:0] LSJD_OP_IN_STR = 8'h6C;
  localparam logic [7:0] LSJD_OP_OUT_STR = 8'h6E;
  localparam logic [7:0] LSJD_OP_LOOP = 8'hF2;
  localparam logic [7:0] LSJD_OP_LOOP_Z = 8'hF3;
  localparam logic [7:0] LSJD_OP_BR_SHORT = 8'hEB;
  localparam logic [7:0] LSJD_OP_BR_NEAR = 8'hE9;
  localparam logic [7:0] LSJD_OP_BR_FAR = 8'hEA;
  // ---------------------------------------------------------------------------
  // addressing byte fields
  // ---------------------------------------------------------------------------
  localparam int LSJD_MOD_HI = 7;
  localparam int LSJD_MOD_LO = 6;
  localparam int LSJD_MID_HI = 5;
  localparam int LSJD_MID_LO = 3;
  localparam logic [1:0] LSJD_MOD_REG = 2'h3;
  localparam logic [2:0] LSJD_MID_TEST = 3'h0;
  // ---------------------------------------------------------------------------
  // cycle costs
  // ---------------------------------------------------------------------------
  localparam logic [15:0] LSJD_CYC_RR = 16'h0003;
  localparam logic [15:0] LSJD_CYC_RM = 16'h000A;
  localparam logic [15:0] LSJD_CYC_IMM_R = 16'h0004;
  localparam logic [15:0] LSJD_CYC_IMM_M = 16'h000A;
  localparam logic [15:0] LSJD_CYC_ACC_B = 16'h0003;
  localparam logic [15:0] LSJD_CYC_ACC_W = 16'h0004;
  localparam logic [15:0] LSJD_CYC_CMP = 16'h0016;
  localparam logic [15:0] LSJD_CYC_SCAN = 16'h000F;
  localparam logic [15:0] LSJD_CYC_LOAD = 16'h000C;
  localparam logic [15:0] LSJD_CYC_STORE = 16'h000A;
  localparam logic [15:0] LSJD_CYC_PORT = 16'h000E;
  localparam logic [15:0] LSJD_CYC_BR = 16'h000E;
  localparam logic [15:0] LSJD_CYC_LOOP_CMP_BASE = 16'h0005;
  localparam logic [15:0] LSJD_CYC_ZERO = 16'h0000;
  localparam logic [15:0] LSJD_CYC_ONE = 16'h0001;
  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    LSJD_K_NONE, LSJD_K_TEST_RM, LSJD_K_TEST_IMM, LSJD_K_TEST_ACC, LSJD_K_OR,
    LSJD_K_XOR, LSJD_K_CMP, LSJD_K_SCAN, LSJD_K_LOAD, LSJD_K_STORE,
    LSJD_K_IN, LSJD_K_OUT, LSJD_K_BR_SHORT, LSJD_K_BR_NEAR, LSJD_K_BR_FAR
  } lsjd_kind_t;

  typedef struct packed {
    lsjd_kind_t kind;
    logic word;
    logic to_reg;
    logic mem;
    logic looped;
    logic loop_z;
    logic [15:0] cycles;
  } lsjd_op_t;

  typedef enum logic [2:0] {
    LSJD_S_IDLE, LSJD_S_OPC, LSJD_S_MODRM, LSJD_S_BYTES, LSJD_S_EXEC, LSJD_S_DONE
  } lsjd_state_t;
endpackage

// ===== rtl/lsjd_classify.sv
// Purpose: classify a first opcode byte into an instruction kind
// Assumes: prefix bytes are stripped by the caller
// Notes: purely combinational
`timescale 1ns/1ps
module lsjd_classify
  import lsjd_pkg::*;
(
  input wire logic [7:0] opc,
  output lsjd_kind_t kind,
  output logic word,
  output logic to_reg,
  output logic has_modrm,
  output logic [2:0] imm_fixed
);
  always_comb begin
    kind = LSJD_K_NONE;
    word = opc[0];
    to_reg = opc[1];
    has_modrm = 1'b0;
    imm_fixed = 3'h0;
    if ((opc & LSJD_MASK_W) == LSJD_OP_TEST_RM) begin
      kind = LSJD_K_TEST_RM;
      has_modrm = 1'b1;
    end else if ((opc & LSJD_MASK_W) == LSJD_OP_GRP3) begin
      kind = LSJD_K_TEST_IMM;
      has_modrm = 1'b1;
    end else if ((opc & LSJD_MASK_W) == LSJD_OP_TEST_ACC) begin
      kind = LSJD_K_TEST_ACC;
      imm_fixed = opc[0] ? 3'h2 : 3'h1;
    end else if ((opc & LSJD_MASK_DW) == LSJD_OP_OR_RM) begin
      kind = LSJD_K_OR;
      has_modrm = 1'b1;
    end else if ((opc & LSJD_MASK_DW) == LSJD_OP_XOR_RM) begin
      kind = LSJD_K_XOR;
      has_modrm = 1'b1;
    end else if ((opc & LSJD_MASK_W) == LSJD_OP_CMP_STR) begin
      kind = LSJD_K_CMP;
    end else if ((opc & LSJD_MASK_W) == LSJD_OP_SCAN_STR) begin
      kind = LSJD_K_SCAN;
    end else if ((opc & LSJD_MASK_W) == LSJD_OP_LOAD_STR) begin
      kind = LSJD_K_LOAD;
    end else if ((opc & LSJD_MASK_W) == LSJD_OP_STORE_STR) begin
      kind = LSJD_K_STORE;
    end else if ((opc & LSJD_MASK_W) == LSJD_OP_IN_STR) begin
      kind = LSJD_K_IN;
    end else if ((opc & LSJD_MASK_W) == LSJD_OP_OUT_STR) begin
      kind = LSJD_K_OUT;
    end else if (opc == LSJD_OP_BR_SHORT) begin
      kind = LSJD_K_BR_SHORT;
      imm_fixed = 3'h1;
    end else if (opc == LSJD_OP_BR_NEAR) begin
      kind = LSJD_K_BR_NEAR;
      imm_fixed = 3'h2;
    end else if (opc == LSJD_OP_BR_FAR) begin
      kind = LSJD_K_BR_FAR;
      imm_fixed = 3'h4;
    end
  end
endmodule

// ===== sim/lsjd_fetch_model.sv
// Purpose: fetch side model offering instruction bytes to the decoder
// Assumes: bytes queued with push are offered in order with valid/ready
// Notes: gap sets idle cycles between bytes; data toggles while idle
`timescale 1ns/1ps
module lsjd_fetch_model
  import lsjd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic byte_ready,
  input wire logic [3:0] gap,
  output logic [7:0] byte_data,
  output logic byte_valid
);
  logic [7:0] q[$];
  logic vld;
  logic taken;
  int idle;

  initial begin
    byte_data = 8'h00;
    byte_valid = 1'b0;
    vld = 1'b0;
    taken = 1'b0;
    idle = 0;
  end

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  // a byte is handed over only at an edge that sees ready high
  always @(posedge core_clk) begin
    if (rst_b && byte_valid && byte_ready) begin
      taken = 1'b1;
    end
  end

  // request held until taken, then released or replaced
  always @(negedge core_clk) begin
    if (taken) begin
      taken = 1'b0;
      void'(q.pop_front());
      vld = 1'b0;
      idle = int'(gap);
    end
    if (!vld && idle > 0) begin
      idle = idle - 1;
    end else if (!vld && q.size() > 0 && rst_b) begin
      vld = 1'b1;
    end
    byte_valid <= vld;
    byte_data <= vld ? q[0] : ~byte_data;
  end
endmodule

// ===== sim/logic_string_jump_decoder_tb_top.sv
// Purpose: self-checking bench for the logic, string and branch decoder
// Assumes: fetch model drives bytes at the falling edge
// Notes: cycle cost measured from the edge taking the opcode byte to done
`timescale 1ns/1ps
module logic_string_jump_decoder_tb_top
  import lsjd_pkg::*;
;
  localparam int LIMIT = 5000;
  logic core_clk;
  logic rst_b;
  logic [7:0] byte_data;
  logic byte_valid;
  logic byte_ready;
  logic [15:0] count_register;
  logic busy;
  logic done;
  logic illegal;
  lsjd_op_t op_info;
  logic [3:0] gap;
  int fails;
  int comparisons;
  int cyc = 0;
  int takes = 0;
  int done_cyc = 0;
  int tcyc[256];

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  lsjd_decoder DUT (.core_clk(core_clk), .rst_b(rst_b), .byte_data(byte_data),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .count_register(count_register),
    .busy(busy), .done(done), .illegal(illegal), .op_info(op_info));

  lsjd_fetch_model fm (.core_clk(core_clk), .rst_b(rst_b), .byte_ready(byte_ready),
    .gap(gap), .byte_data(byte_data), .byte_valid(byte_valid));

  // ---------------------------------------------------------------------------
  // monitors and helpers
  // ---------------------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (byte_valid && byte_ready) begin
      tcyc[takes % 256] <= cyc;
      takes <= takes + 1;
    end
    if (done) begin
      done_cyc <= cyc;
    end
    if (cyc == LIMIT) begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end

  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // x enables checks of {word, to_reg, mem}; e holds expected {to_reg, mem}
  task automatic run(input logic [39:0] b, input int n, input lsjd_kind_t k,
                     input logic w, input logic [15:0] cy, input logic [2:0] x,
                     input logic [1:0] e);
    int base;
    int pre;
    int t;
    logic rp;
    logic rz;
    logic refused;
    base = takes;
    rp = 1'bx;
    rz = 1'bx;
    refused = 1'b0;
    pre = (b[7:1] == 7'h79) ? 1 : 0;
    for (int i = 0; i < n; i++) fm.push(b[8*i+:8]);
    t = 0;
    do begin
      @(negedge core_clk);
      t++;
      // repeat flags are dropped as done rises, so catch them while busy
      if (busy === 1'b1) begin
        rp = op_info.looped;
        rz = op_info.loop_z;
      end
      if (illegal !== 1'b0) begin
        refused = 1'b1;
      end
    end while (done !== 1'b1 && t < 3000);
    check(done === 1'b1, "no done");
    check(refused === 1'b0, "unexpected refusal");
    @(posedge core_clk);
    #1;
    if (gap == 4'h0) begin
      check(done_cyc - tcyc[(base + pre) % 256] - 1 == int'(cy), "cycle count");
    end
    check(op_info.kind === k && op_info.cycles === cy, "kind or cost");
    check(rp === (pre == 1) && rz === (pre == 1 && b[0]), "repeat");
    check(!x[2] || op_info.word === w, "size");
    check(!x[1] || op_info.to_reg === e[1], "direction");
    check(!x[0] || op_info.mem === e[0], "operand kind");
    @(negedge core_clk);
  endtask

  task automatic bad(input logic [15:0] b, input int n);
    int t;
    for (int i = 0; i < n; i++) fm.push(b[8*i+:8]);
    t = 0;
    do begin
      @(negedge core_clk);
      t++;
    end while (illegal !== 1'b1 && t < 50);
    check(illegal === 1'b1 && done === 1'b0, "not refused");
    @(negedge core_clk);
    check(busy === 1'b0 && fm.q.size() == 0 && byte_ready === 1'b1, "no recovery");
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_test_forms();
    run(40'h00_0000_C084, 2, LSJD_K_TEST_RM, 1'h0, 16'h0003, 3'h5, 2'h0);
    run(40'h00_0000_0085, 2, LSJD_K_TEST_RM, 1'h1, 16'h000A, 3'h5, 2'h1);
    run(40'h00_0055_C0F6, 3, LSJD_K_TEST_IMM, 1'h0, 16'h0004, 3'h5, 2'h0);
    run(40'h00_1234_00F7, 4, LSJD_K_TEST_IMM, 1'h1, 16'h000A, 3'h5, 2'h1);
    run(40'h00_1234_C0F7, 4, LSJD_K_TEST_IMM, 1'h1, 16'h0004, 3'h5, 2'h0);
    run(40'h00_0000_55A8, 2, LSJD_K_TEST_ACC, 1'h0, 16'h0003, 3'h4, 2'h0);
    run(40'h00_0012_34A9, 3, LSJD_K_TEST_ACC, 1'h1, 16'h0004, 3'h4, 2'h0);
  endtask

  task automatic t_or_xor();
    run(40'h00_0000_C008, 2, LSJD_K_OR, 1'h0, 16'h0003, 3'h7, 2'h0);
    run(40'h00_0000_000B, 2, LSJD_K_OR, 1'h1, 16'h000A, 3'h7, 2'h3);
    run(40'h00_0000_C031, 2, LSJD_K_XOR, 1'h1, 16'h0003, 3'h7, 2'h0);
    run(40'h00_0000_0032, 2, LSJD_K_XOR, 1'h0, 16'h000A, 3'h7, 2'h3);
  endtask

  task automatic t_strings();
    run(40'h00_0000_00A6, 1, LSJD_K_CMP, 1'h0, 16'h0016, 3'h4, 2'h0);
    run(40'h00_0000_00AF, 1, LSJD_K_SCAN, 1'h1, 16'h000F, 3'h4, 2'h0);
    run(40'h00_0000_00AC, 1, LSJD_K_LOAD, 1'h0, 16'h000C, 3'h4, 2'h0);
    run(40'h00_0000_00AB, 1, LSJD_K_STORE, 1'h1, 16'h000A, 3'h4, 2'h0);
    run(40'h00_0000_006D, 1, LSJD_K_IN, 1'h1, 16'h000E, 3'h4, 2'h0);
    run(40'h00_0000_006E, 1, LSJD_K_OUT, 1'h0, 16'h000E, 3'h4, 2'h0);
  endtask

  task automatic t_repeat();
    count_register = 16'h0003;
    run(40'h00_0000_A6F2, 2, LSJD_K_CMP, 1'h0, 16'h0047, 3'h4, 2'h0);
    count_register = 16'h0000;
    run(40'h00_0000_A7F3, 2, LSJD_K_CMP, 1'h1, 16'h0005, 3'h4, 2'h0);
    run(40'h00_0000_AEF3, 2, LSJD_K_SCAN, 1'h0, 16'h000F, 3'h4, 2'h0);
    run(40'h00_0000_AAF2, 2, LSJD_K_STORE, 1'h0, 16'h000A, 3'h4, 2'h0);
  endtask

  task automatic t_branch();
    run(40'h00_0000_10EB, 2, LSJD_K_BR_SHORT, 1'h0, 16'h000E, 3'h0, 2'h0);
    run(40'h00_0012_34E9, 3, LSJD_K_BR_NEAR, 1'h0, 16'h000E, 3'h0, 2'h0);
    run(40'hF0_0010_00EA, 5, LSJD_K_BR_FAR, 1'h0, 16'h000E, 3'h0, 2'h0);
  endtask

  task automatic t_illegal();
    bad(16'h08F6, 2);
    bad(16'hEBF2, 2);
    bad(16'hAAF3, 2);
    bad(16'h0000, 1);
  endtask

  task automatic t_stall();
    gap = 4'h3;
    run(40'h00_1234_00F7, 4, LSJD_K_TEST_IMM, 1'h1, 16'h000A, 3'h5, 2'h1);
    run(40'h00_0000_C0F6, 3, LSJD_K_TEST_IMM, 1'h0, 16'h0004, 3'h5, 2'h0);
    gap = 4'h0;
  endtask

  initial begin
    rst_b = 1'b0;
    count_register = 16'h0000;
    gap = 4'h0;
    fails = 0;
    comparisons = 0;
    repeat (6) @(negedge core_clk);
    check(busy === 1'b0 && done === 1'b0 && illegal === 1'b0 && op_info === '0, "reset");
    rst_b = 1'b1;
    @(negedge core_clk);
    check(byte_ready === 1'b1, "not ready after reset");
    t_test_forms();
    t_or_xor();
    t_strings();
    t_repeat();
    t_branch();
    t_illegal();
    t_stall();
    end_sim();
  end
endmodule
